/* hw/enc_device.sv */
`timescale 1ns/10ps
`include "enc_params.svh"
module enc_device #(
  parameter logic [31:0] SERIAL_VER = 32'h0000_0001, // Arbitrary value
  parameter int FIELD_WORDS = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  enc_link_if.dev link,
  input wire logic [`POS_BITS-1:0] raw_pos,
  input wire enc_pkg::byte_t temperature,
  input wire logic analog_fault,
  input wire logic current_fault,
  input wire logic scratch_ram_fault,
  input wire logic temp_fault,
  output logic [`POS_BITS-1:0] position,
  output enc_pkg::byte_t link_config,
  output enc_pkg::byte_t status_code
);
  import enc_pkg::*;
  localparam int AW = $clog2(FIELD_WORDS);

  function automatic logic is_protected(input byte_t c);
    is_protected = (c == `CMD_SET_POS) || (c == `CMD_DEL_CNT) || (c == `CMD_STORE_DATA) ||
      (c == `CMD_CREATE_FIELD) || (c == `CMD_CHANGE_KEY) || (c == `CMD_CONFIG_LINK);
  endfunction : is_protected

  // Argument bytes expected, key byte included; 4'hF marks an unknown command
  function automatic logic [3:0] arg_count(input byte_t c);
    case (c)
      `CMD_READ_POS, `CMD_READ_CNT, `CMD_INC_CNT, `CMD_FREE_MEM, `CMD_READ_STATUS,
      `CMD_SERIAL_VER: arg_count = 4'd0;
      `CMD_READ_ANALOG, `CMD_FIELD_STATUS: arg_count = 4'd1;
      `CMD_DEL_CNT: arg_count = 4'd1;
      `CMD_READ_DATA: arg_count = 4'd1;
      `CMD_CHANGE_KEY, `CMD_CONFIG_LINK, `CMD_CREATE_FIELD: arg_count = 4'd2;
      `CMD_STORE_DATA, `CMD_SET_POS: arg_count = 4'd3;
      default: arg_count = 4'hF;
    endcase
  endfunction : arg_count

  dev_state_t st_r, st_nxt;
  byte_t cmd_r, cmd_nxt, key_r, key_nxt, cfg_r, cfg_nxt, err_r, err_nxt, sum_r, sum_nxt;
  byte_t arg_r [0:3];
  byte_t arg_nxt [0:3];
  logic [3:0] cnt_r, cnt_nxt;
  logic [`POS_BITS-1:0] off_r, off_nxt;
  logic [15:0] counter_r, counter_nxt;
  logic [15:0] field_size_r, field_size_nxt;
  byte_t field_mem [0:FIELD_WORDS-1];
  logic mem_we;
  byte_t rsp_r [0:4];
  byte_t rsp_nxt [0:4];
  logic [2:0] rlen_r, rlen_nxt, ridx_r, ridx_nxt;
  logic [`POS_BITS-1:0] pos_now;
  logic [AW-1:0] addr;
  // Set only by an error that the current command itself raised
  logic cmd_err;

  assign pos_now = `POS_BITS'(raw_pos - off_r);
  assign addr = AW'(arg_r[0]);

  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    key_nxt = key_r;
    cfg_nxt = cfg_r;
    err_nxt = err_r;
    sum_nxt = sum_r;
    cnt_nxt = cnt_r;
    off_nxt = off_r;
    counter_nxt = counter_r;
    field_size_nxt = field_size_r;
    rlen_nxt = rlen_r;
    ridx_nxt = ridx_r;
    mem_we = 1'b0;
    cmd_err = 1'b0;
    for (int i = 0; i < 4; i++) begin
      arg_nxt[i] = arg_r[i];
    end
    for (int i = 0; i < 5; i++) begin
      rsp_nxt[i] = rsp_r[i];
    end
    // Monitoring faults, lowest priority first so the last wins
    if (temp_fault) begin
      err_nxt = `ST_TEMP;
    end
    if (current_fault || scratch_ram_fault) begin
      err_nxt = `ST_CURRENT_RAM;
    end
    if (analog_fault) begin
      err_nxt = `ST_ANALOG;
    end
    case (st_r)
      DEV_IDLE: begin
        if (link.req_valid) begin
          cmd_nxt = link.req_byte;
          sum_nxt = link.req_byte;
          cnt_nxt = 4'd0;
          st_nxt = link.req_last ? DEV_REPLY : DEV_ARGS;
          if (link.req_parity_err) begin
            err_nxt = `ST_PARITY;
          end
        end
      end
      DEV_ARGS: begin
        if (link.req_valid) begin
          if (cnt_r < 4'd4) begin
            arg_nxt[cnt_r[1:0]] = link.req_byte;
          end
          cnt_nxt = 4'(cnt_r + 4'd1);
          sum_nxt = sum_r ^ link.req_byte;
          if (link.req_parity_err) begin
            err_nxt = `ST_PARITY;
          end
          if (link.req_last) begin
            st_nxt = DEV_REPLY;
          end
        end
      end
      DEV_REPLY: begin
        if (ridx_r == 3'd0 && rlen_r == 3'd0) begin
          // Decode and execute once the frame is complete
          rsp_nxt[0] = cmd_r;
          rlen_nxt = 3'd1;
          if (arg_count(cmd_r) == 4'hF) begin
            err_nxt = `ST_UNKNOWN;
            cmd_err = 1'b1;
          end else if (cnt_r != 4'(arg_count(cmd_r) + 4'd1)) begin
            err_nxt = `ST_COUNT;
            cmd_err = 1'b1;
          end else if (sum_r != 8'h00) begin
            // Frame XOR including trailing check byte must be zero
            err_nxt = `ST_CHECKSUM;
            cmd_err = 1'b1;
          end else if (is_protected(cmd_r) && arg_r[0] != key_r) begin
            err_nxt = `ST_BAD_KEY;
            cmd_err = 1'b1;
          end else begin
            case (cmd_r)
              `CMD_READ_POS: begin
                rsp_nxt[1] = {1'b0, pos_now[14:8]};
                rsp_nxt[2] = pos_now[7:0];
                rlen_nxt = 3'd3;
              end
              `CMD_SET_POS: off_nxt = `POS_BITS'(raw_pos - {arg_r[1][6:0], arg_r[2]});
              `CMD_READ_ANALOG: begin
                rsp_nxt[1] = temperature;
                rlen_nxt = 3'd2;
              end
              `CMD_READ_CNT: begin
                rsp_nxt[1] = counter_r[15:8];
                rsp_nxt[2] = counter_r[7:0];
                rlen_nxt = 3'd3;
              end
              `CMD_INC_CNT: counter_nxt = 16'(counter_r + 16'd1);
              `CMD_DEL_CNT: counter_nxt = 16'h0000;
              `CMD_READ_DATA: begin
                if (arg_r[0] >= 8'(FIELD_WORDS)) begin
                  err_nxt = `ST_ARG;
                  cmd_err = 1'b1;
                end else begin
                  rsp_nxt[1] = field_mem[addr];
                  rlen_nxt = 3'd2;
                end
              end
              `CMD_STORE_DATA: begin
                if (arg_r[1] >= 8'(FIELD_WORDS)) begin
                  err_nxt = `ST_ARG;
                  cmd_err = 1'b1;
                end else begin
                  mem_we = 1'b1;
                end
              end
              `CMD_FIELD_STATUS: begin
                rsp_nxt[1] = field_size_r[7:0];
                rlen_nxt = 3'd2;
              end
              `CMD_CREATE_FIELD: field_size_nxt = {8'h00, arg_r[1]};
              `CMD_FREE_MEM: begin
                rsp_nxt[1] = 8'(16'(`FREE_MEM_BYTES - field_size_r) >> 8);
                rsp_nxt[2] = 8'(`FREE_MEM_BYTES - field_size_r);
                rlen_nxt = 3'd3;
              end
              `CMD_CHANGE_KEY: key_nxt = arg_r[1];
              `CMD_READ_STATUS: begin
                rsp_nxt[1] = err_r;
                rlen_nxt = 3'd2;
                // A fault still present wins over the clear
                if (!(analog_fault || current_fault || scratch_ram_fault || temp_fault)) begin
                  err_nxt = `ST_OK;
                end
              end
              `CMD_SERIAL_VER: begin
                rsp_nxt[1] = SERIAL_VER[31:24];
                rsp_nxt[2] = SERIAL_VER[23:16];
                rsp_nxt[3] = SERIAL_VER[15:8];
                rsp_nxt[4] = SERIAL_VER[7:0];
                rlen_nxt = 3'd5;
              end
              `CMD_CONFIG_LINK: cfg_nxt = arg_r[1];
              default: err_nxt = `ST_UNKNOWN;
            endcase
          end
          if (cmd_err) begin
            rsp_nxt[0] = 8'h80 | cmd_r;
          end
        end else begin
          ridx_nxt = 3'(ridx_r + 3'd1);
          if (ridx_r == 3'(rlen_r - 3'd1)) begin
            ridx_nxt = 3'd0;
            rlen_nxt = 3'd0;
            st_nxt = DEV_IDLE;
          end
        end
      end
      default: st_nxt = DEV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= DEV_IDLE;
      cmd_r <= 8'h00;
      key_r <= `KEY_RESET;
      cfg_r <= `LINK_CFG_RESET;
      err_r <= `ST_OK;
      sum_r <= 8'h00;
      cnt_r <= 4'h0;
      off_r <= '0;
      counter_r <= 16'h0000;
      field_size_r <= 16'h0000;
      rlen_r <= 3'h0;
      ridx_r <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        arg_r[i] <= 8'h00;
      end
      for (int i = 0; i < 5; i++) begin
        rsp_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      key_r <= key_nxt;
      cfg_r <= cfg_nxt;
      err_r <= err_nxt;
      sum_r <= sum_nxt;
      cnt_r <= cnt_nxt;
      off_r <= off_nxt;
      counter_r <= counter_nxt;
      field_size_r <= field_size_nxt;
      rlen_r <= rlen_nxt;
      ridx_r <= ridx_nxt;
      for (int i = 0; i < 4; i++) begin
        arg_r[i] <= arg_nxt[i];
      end
      for (int i = 0; i < 5; i++) begin
        rsp_r[i] <= rsp_nxt[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      field_mem[AW'(arg_r[1])] <= arg_r[2];
    end
  end

  assign link.req_ready = (st_r != DEV_REPLY);
  assign link.rsp_valid = (st_r == DEV_REPLY) && (rlen_r != 3'd0);
  assign link.rsp_byte = rsp_r[ridx_r];
  assign link.rsp_last = link.rsp_valid && (ridx_r == 3'(rlen_r - 3'd1));
  assign position = pos_now;
  assign link_config = cfg_r;
  assign status_code = err_r;
endmodule : enc_device

/* hw/enc_params.svh */
`ifndef ENC_PARAMS_SVH
`define ENC_PARAMS_SVH
`define CMD_READ_POS 8'h42
`define CMD_SET_POS 8'h43
`define CMD_READ_ANALOG 8'h44
`define CMD_READ_CNT 8'h46
`define CMD_INC_CNT 8'h47
`define CMD_DEL_CNT 8'h49
`define CMD_READ_DATA 8'h4A
`define CMD_STORE_DATA 8'h4B
`define CMD_FIELD_STATUS 8'h4C
`define CMD_CREATE_FIELD 8'h4D
`define CMD_FREE_MEM 8'h4E
`define CMD_CHANGE_KEY 8'h4F
`define CMD_READ_STATUS 8'h50
`define CMD_SERIAL_VER 8'h56
`define CMD_CONFIG_LINK 8'h57
`define ST_OK 8'h00
`define ST_PARITY 8'h09
`define ST_CHECKSUM 8'h0A
`define ST_UNKNOWN 8'h0B
`define ST_COUNT 8'h0C
`define ST_ARG 8'h0D
`define ST_BAD_KEY 8'h0F
`define ST_ANALOG 8'h1C
`define ST_CURRENT_RAM 8'h1D
`define ST_TEMP 8'h1E
`define KEY_RESET 8'h55
`define FREE_MEM_BYTES 16'h0700
`define LINK_CFG_RESET 8'hE4
`define POS_BITS 15
`endif

/* hw/enc_pkg.sv */
package enc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {DEV_IDLE, DEV_ARGS, DEV_REPLY} dev_state_t;
  typedef enum logic [1:0] {CTL_IDLE, CTL_SEND, CTL_WAIT} ctl_state_t;
endpackage : enc_pkg

/* hw/enc_link_if.sv */
`timescale 1ns/10ps
interface enc_link_if;
  // Controller to device byte stream
  logic req_valid;
  logic req_ready;
  logic [7:0] req_byte;
  logic req_last;
  logic req_parity_err;
  // Device to controller byte stream
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_last;
  modport ctl (output req_valid, req_byte, req_last, req_parity_err, input req_ready, rsp_valid, rsp_byte, rsp_last);
  modport dev (input req_valid, req_byte, req_last, req_parity_err, output req_ready, rsp_valid, rsp_byte, rsp_last);
endinterface : enc_link_if

/* hw/enc_controller.sv */
`timescale 1ns/10ps
`include "enc_params.svh"
module enc_controller (
  input wire logic sys_clk,
  input wire logic rst_b,
  enc_link_if.ctl link,
  input wire logic cmd_start,
  input wire enc_pkg::byte_t cmd_code,
  input wire logic cmd_protected,
  input wire enc_pkg::byte_t cmd_key,
  input wire logic [2:0] cmd_nargs,
  input wire logic [31:0] cmd_args,
  output logic cmd_busy,
  output logic rsp_out_valid,
  output enc_pkg::byte_t rsp_out_byte,
  output logic rsp_out_last
);
  import enc_pkg::*;
  ctl_state_t st_r, st_nxt;
  byte_t buf_r [0:5];
  byte_t buf_nxt [0:5];
  logic [2:0] len_r, len_nxt, idx_r, idx_nxt;
  logic rv_r, rl_r;
  byte_t rb_r;
  always_comb begin
    st_nxt = st_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    for (int i = 0; i < 6; i++) begin
      buf_nxt[i] = buf_r[i];
    end
    case (st_r)
      CTL_IDLE: begin
        if (cmd_start) begin
          buf_nxt[0] = cmd_code;
          // Key byte follows the command byte on protected commands
          buf_nxt[1] = cmd_key;
          for (int i = 0; i < 4; i++) begin
            buf_nxt[(cmd_protected ? 2 : 1) + i] = cmd_args[8*i +: 8];
          end
          len_nxt = 3'(cmd_nargs + (cmd_protected ? 3'd2 : 3'd1));
          idx_nxt = 3'd0;
          st_nxt = CTL_SEND;
        end
      end
      CTL_SEND: begin
        if (link.req_ready) begin
          idx_nxt = 3'(idx_r + 3'd1);
          if (idx_r == 3'(len_r - 3'd1)) begin
            st_nxt = CTL_WAIT;
          end
        end
      end
      CTL_WAIT: begin
        if (link.rsp_valid && link.rsp_last) begin
          st_nxt = CTL_IDLE;
        end
      end
      default: st_nxt = CTL_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= CTL_IDLE;
      len_r <= 3'h0;
      idx_r <= 3'h0;
      rv_r <= 1'b0;
      rl_r <= 1'b0;
      rb_r <= 8'h00;
      for (int i = 0; i < 6; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      for (int i = 0; i < 6; i++) begin
        buf_r[i] <= buf_nxt[i];
      end
      rv_r <= link.rsp_valid;
      rl_r <= link.rsp_valid & link.rsp_last;
      if (link.rsp_valid) begin
        rb_r <= link.rsp_byte;
      end
    end
  end
  assign link.req_valid = (st_r == CTL_SEND);
  assign link.req_byte = buf_r[idx_r];
  assign link.req_last = (st_r == CTL_SEND) && (idx_r == 3'(len_r - 3'd1));
  assign link.req_parity_err = 1'b0;
  assign cmd_busy = (st_r != CTL_IDLE);
  assign rsp_out_valid = rv_r;
  assign rsp_out_byte = rb_r;
  assign rsp_out_last = rl_r;
endmodule : enc_controller

/* tb/enc_link_asserts.sv */
`timescale 1ns/10ps
module enc_link_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  input wire logic req_parity_err,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last
);
  logic first_r;
  logic first_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] sum_r;
  logic [7:0] sum_nxt;
  wire logic take = req_valid && req_ready;

  // Command byte and running XOR of the frame being received
  always_comb begin
    first_nxt = first_r;
    cmd_nxt = cmd_r;
    sum_nxt = sum_r;
    if (take) begin
      first_nxt = req_last;
      cmd_nxt = first_r ? req_byte : cmd_r;
      sum_nxt = first_r ? req_byte : sum_r ^ req_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
      cmd_r <= 8'h00;
      sum_r <= 8'h00;
    end else begin
      first_r <= first_nxt;
      cmd_r <= cmd_nxt;
      sum_r <= sum_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_two_tail;
    (rsp_valid && !rsp_byte[7] && !rsp_last) ##1 (rsp_valid && rsp_last);
  endsequence
  sequence s_four_tail;
    (rsp_valid && !rsp_last) [*3] ##1 (rsp_valid && rsp_last);
  endsequence

  property p_decode_gap;
    take && req_last |=> !rsp_valid ##1 rsp_valid;
  endproperty
  property p_refuse;
    rsp_valid |-> !req_ready;
  endproperty
  property p_burst;
    rsp_valid && !rsp_last |=> rsp_valid;
  endproperty
  property p_echo;
    $rose(rsp_valid) |-> rsp_byte[6:0] == cmd_r[6:0];
  endproperty
  property p_sum_err;
    $rose(rsp_valid) && sum_r != 8'h00 |-> rsp_byte[7];
  endproperty
  property p_unknown;
    $rose(rsp_valid) && !(cmd_r inside {8'h42, 8'h43, 8'h44, 8'h46, 8'h47, 8'h49, 8'h4A, 8'h4B, 8'h4C,
      8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h56, 8'h57}) |-> rsp_byte[7];
  endproperty
  property p_pos_len;
    $rose(rsp_valid) && rsp_byte == 8'h42 |=> s_two_tail;
  endproperty
  property p_free_len;
    $rose(rsp_valid) && rsp_byte == 8'h4E |=> s_two_tail;
  endproperty
  property p_ser_len;
    $rose(rsp_valid) && rsp_byte == 8'h56 |=> s_four_tail;
  endproperty

  a_decode_gap: assert property (p_decode_gap) else $error("reply not after one decode cycle");
  a_refuse: assert property (p_refuse) else $error("request taken while replying");
  a_burst: assert property (p_burst) else $error("gap inside reply");
  a_echo: assert property (p_echo) else $error("reply does not echo command");
  a_sum_err: assert property (p_sum_err) else $error("bad checksum not flagged");
  a_unknown: assert property (p_unknown) else $error("unknown command not flagged");
  a_pos_len: assert property (p_pos_len) else $error("position reply malformed");
  a_free_len: assert property (p_free_len) else $error("free memory reply malformed");
  a_ser_len: assert property (p_ser_len) else $error("serial reply malformed");
endmodule : enc_link_asserts

/* tb/encoder_param_command_decoder_tb_top.sv */
`timescale 1ns/10ps
module encoder_param_command_decoder_tb_top;
  import enc_pkg::*;
  logic sys_clk, rst_b, cmd_start, cmd_protected, cmd_busy, rsp_out_valid, rsp_out_last;
  logic analog_fault, current_fault, scratch_ram_fault, temp_fault;
  byte_t cmd_code, cmd_key, rsp_out_byte, temperature, link_config, status_code;
  logic [2:0] cmd_nargs;
  logic [31:0] cmd_args;
  logic [14:0] raw_pos, position;
  byte_t rq[$];
  int n_mismatch, checked;
  enc_link_if link();
  enc_controller u_enc_controller (.sys_clk, .rst_b, .link, .cmd_start, .cmd_code, .cmd_protected, .cmd_key,
    .cmd_nargs, .cmd_args, .cmd_busy, .rsp_out_valid, .rsp_out_byte, .rsp_out_last);
  enc_device u_enc_device (.sys_clk, .rst_b, .link, .raw_pos, .temperature, .analog_fault, .current_fault,
    .scratch_ram_fault, .temp_fault, .position, .link_config, .status_code);
  enc_link_asserts u_enc_link_asserts (.sys_clk, .rst_b, .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_byte(link.req_byte), .req_last(link.req_last), .req_parity_err(link.req_parity_err),
    .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // One frame; the check byte is appended, flipped in bit 0 when bad is set
  task automatic xfer(byte_t code, logic prot, byte_t key, int n, logic [23:0] a, logic bad = 1'b0);
    byte_t x;
    int w;
    x = code ^ (prot ? key : 8'h00);
    for (int i = 0; i < n; i++) x ^= a[8*i +: 8];
    x ^= {7'h00, bad};
    cmd_code = code;
    cmd_protected = prot;
    cmd_key = key;
    cmd_nargs = 3'(n + 1);
    cmd_args = {8'h00, a} | (32'(x) << (8 * n));
    cmd_start = 1'b1;
    tick;
    cmd_start = 1'b0;
    rq.delete();
    w = 0;
    do begin
      tick;
      w++;
      if (rsp_out_valid === 1'b1) rq.push_back(rsp_out_byte);
    end while (!(rsp_out_valid === 1'b1 && rsp_out_last === 1'b1) && w < 60);
    chk("reply_done", {31'h0, (w < 60)}, 32'h1);
    tick;
    tick;
  endtask : xfer

  // Faulty frame: flagged echo, latched code, read back and cleared by the status read
  task automatic err(byte_t code, logic prot, byte_t key, int n, logic [23:0] a, logic bad, byte_t st);
    xfer(code, prot, key, n, a, bad);
    chk("err_echo", rq[0], code | 8'h80);
    chk("err_status", status_code, st);
    xfer(8'h50, 1'b0, 8'h00, 0, 24'h0);
    chk("status_read", rq[1], st);
    chk("status_clear", status_code, 8'h00);
  endtask : err

  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {cmd_start, cmd_protected, analog_fault, current_fault, scratch_ram_fault, temp_fault} = '0;
    cmd_code = 8'h00;
    cmd_key = 8'h00;
    cmd_nargs = 3'h0;
    cmd_args = 32'h0;
    raw_pos = 15'h5A3C;
    temperature = 8'h2D;
    rst_b = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    chk("link_cfg_reset", link_config, 8'hE4);
    chk("status_reset", status_code, 8'h00);
    xfer(8'h42, 1'b0, 8'h00, 0, 24'h0);
    chk("pos_reply", {rq[0], rq[1], rq[2]}, {8'h42, 1'b0, raw_pos});
    chk("position", position, raw_pos);
    err(8'h45, 1'b0, 8'h00, 0, 24'h0, 1'b0, 8'h0B);
    err(8'h42, 1'b0, 8'h00, 0, 24'h0, 1'b1, 8'h0A);
    err(8'h42, 1'b0, 8'h00, 1, 24'h11, 1'b0, 8'h0C);
    err(8'h4A, 1'b0, 8'h00, 1, 24'h10, 1'b0, 8'h0D);
    err(8'h4F, 1'b1, 8'h56, 1, 24'hA5, 1'b0, 8'h0F);
    xfer(8'h4E, 1'b0, 8'h00, 0, 24'h0);
    chk("free_mem", {rq[0], rq[1], rq[2]}, 24'h4E0700);
    xfer(8'h4F, 1'b1, 8'h55, 1, 24'hA5);
    chk("key_change", rq[0], 8'h4F);
    err(8'h57, 1'b1, 8'h55, 1, 24'h3C, 1'b0, 8'h0F);
    xfer(8'h57, 1'b1, 8'hA5, 1, 24'h3C);
    chk("link_cfg", link_config, 8'h3C);
    xfer(8'h4B, 1'b1, 8'hA5, 2, 24'h5A03);
    chk("store_echo", rq[0], 8'h4B);
    xfer(8'h4A, 1'b0, 8'h00, 1, 24'h03);
    chk("read_data", {rq[0], rq[1]}, 16'h4A5A);
    xfer(8'h4C, 1'b0, 8'h00, 1, 24'h03);
    chk("field_status", {rq[0], rq[1]}, 16'h4C00);
    xfer(8'h4D, 1'b1, 8'hA5, 1, 24'h04);
    chk("field_create", rq[0], 8'h4D);
    xfer(8'h4C, 1'b0, 8'h00, 1, 24'h03);
    chk("field_size", rq[1], 8'h04);
    xfer(8'h4E, 1'b0, 8'h00, 0, 24'h0);
    chk("free_after_create", {rq[1], rq[2]}, 16'h06FC);
    xfer(8'h56, 1'b0, 8'h00, 0, 24'h0);
    chk("serial_echo", rq[0], 8'h56);
    chk("serial_ver", {rq[1], rq[2], rq[3], rq[4]}, 32'h0000_0001);
    xfer(8'h43, 1'b1, 8'hA5, 2, 24'h3412);
    chk("set_pos", rq[0], 8'h43);
    chk("pos_loaded", position, 15'h1234);
    xfer(8'h42, 1'b0, 8'h00, 0, 24'h0);
    chk("pos_after_set", {rq[1], rq[2]}, 16'h1234);
    xfer(8'h44, 1'b0, 8'h00, 1, 24'h48);
    chk("analog_temp", {rq[0], rq[1]}, {8'h44, temperature});
    xfer(8'h47, 1'b0, 8'h00, 0, 24'h0);
    xfer(8'h46, 1'b0, 8'h00, 0, 24'h0);
    chk("counter_inc", {rq[0], rq[1], rq[2]}, 24'h460001);
    err(8'h49, 1'b1, 8'h55, 0, 24'h0, 1'b0, 8'h0F);
    xfer(8'h49, 1'b1, 8'hA5, 0, 24'h0);
    xfer(8'h46, 1'b0, 8'h00, 0, 24'h0);
    chk("counter_del", {rq[1], rq[2]}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      {analog_fault, current_fault, scratch_ram_fault, temp_fault} = (i == 4) ? 4'b1001 : 4'b1000 >> i;
      tick;
      tick;
      chk("fault", status_code, (i == 0 || i == 4) ? 8'h1C : (i == 3) ? 8'h1E : 8'h1D);
      {analog_fault, current_fault, scratch_ram_fault, temp_fault} = 4'b0000;
      xfer(8'h50, 1'b0, 8'h00, 0, 24'h0);
    end
    temp_fault = 1'b1;
    xfer(8'h50, 1'b0, 8'h00, 0, 24'h0);
    chk("fault_read", rq[1], 8'h1E);
    chk("fault_over_clear", status_code, 8'h1E);
    temp_fault = 1'b0;
    xfer(8'h50, 1'b0, 8'h00, 0, 24'h0);
    chk("fault_gone", status_code, 8'h00);
    rst_b = 1'b0;
    tick;
    rst_b = 1'b1;
    chk("link_cfg_reset2", link_config, 8'hE4);
    xfer(8'h57, 1'b1, 8'h55, 1, 24'h3C);
    chk("key_reset", {rq[0], link_config}, 16'h573C);
    print_verdict();
  end
endmodule : encoder_param_command_decoder_tb_top
